// file: rtl/sdf_fifo.sv
// Strobed 1024 x 18 FIFO with fall-through, flags and offset programming
// Overview of operation
// - Stores 1024 words of 18 bits from the write data inputs.
// - Rising write strobe stores a word when not full.
// - Full when writes exceed reads by 1024; then writes ignored.
// - Rising read strobe advances when not empty; else ignored.
// - Reset clears pointers; full_n high, almost high, half low, empty_n low.
// - Output enable low floats read data; otherwise driven true.
// - First write after empty shows its word without read strobe.
// - Later words appear only after a rising read strobe.
// - Half-full flag high while 512 or more words held.
// - Almost flag high when count at most X or at least 1024-X.
// - Falling offset-define captures data bits 0..8 as candidate offset.
// - Offset-define high through reset selects default offset 256.
// - Offset chosen afresh each reset cycle, otherwise held.
// - Works with strobes asynchronous or coincident.
`timescale 1ns/10ps
`default_nettype none
`include "sdf_defs.svh"
module sdf_fifo (
	input  wire logic                   CORE_CLK_I,       // 100 MHz core clock
	input  wire logic                   SYS_RST_I,        // Sync reset, high
	input  wire logic                   RESET_N_I,        // Device reset pin, low
	input  wire logic                   WRITE_STROBE_I,   // Write strobe pin
	input  wire logic                   READ_STROBE_I,    // Read strobe pin
	input  wire logic                   OFFSET_DEFINE_N_I,// Offset-define pin
	input  wire logic                   OUT_ENABLE_I,     // Output enable pin
	input  wire logic [`SDF_WIDTH-1:0]  WRITE_DATA_IN_I,  // Write data
	output logic      [`SDF_WIDTH-1:0]  READ_DATA_OUT_O,  // Read data
	output logic      [`SDF_WIDTH-1:0]  READ_DATA_OE_N_O, // Read data enable, low drives
	output logic                        FULL_N_O,         // Low when full
	output logic                        EMPTY_N_O,        // Low when empty
	output logic                        HALF_FULL_FLAG_O, // 512 or more held
	output logic                        ALMOST_BOUND_FLAG_O // Near either bound
);
	// Control pins pass two flops before use; data passes three, one more than the strobe
	// Data is taken from the cycle before the strobe edge is seen, a setup margin
	logic [2:0]            wr_s_q;
	logic [2:0]            rd_s_q;
	logic [2:0]            daf_s_q;
	logic [1:0]            rst_s_q;
	logic [1:0]            oe_s_q;
	logic [`SDF_WIDTH-1:0] din1_q;
	logic [`SDF_WIDTH-1:0] din2_q;
	logic [`SDF_WIDTH-1:0] din3_q;
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			wr_s_q  <= 3'h0;
			rd_s_q  <= 3'h0;
			daf_s_q <= 3'h7;
			rst_s_q <= 2'h0;
			oe_s_q  <= 2'h0;
			din1_q  <= '0;
			din2_q  <= '0;
			din3_q  <= '0;
		end else begin
			wr_s_q  <= {wr_s_q[1:0], WRITE_STROBE_I};
			rd_s_q  <= {rd_s_q[1:0], READ_STROBE_I};
			daf_s_q <= {daf_s_q[1:0], OFFSET_DEFINE_N_I};
			rst_s_q <= {rst_s_q[0], RESET_N_I};
			oe_s_q  <= {oe_s_q[0], OUT_ENABLE_I};
			din1_q  <= WRITE_DATA_IN_I;
			din2_q  <= din1_q;
			din3_q  <= din2_q;
		end
	end
	wire dev_rst  = SYS_RST_I | ~rst_s_q[1];
	wire wr_rise  = wr_s_q[1] & ~wr_s_q[2];
	wire rd_rise  = rd_s_q[1] & ~rd_s_q[2];
	wire daf_fall = ~daf_s_q[1] & daf_s_q[2];

	// Offset programming
	logic [`SDF_OFS_W-1:0] cand_q;
	logic [`SDF_OFS_W-1:0] ofs_q;
	logic                  cand_vld_q;
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			cand_q     <= `SDF_OFS_DEF;
			cand_vld_q <= 1'b0;
		end else if (daf_fall) begin
			cand_q     <= din3_q[`SDF_OFS_W-1:0];
			cand_vld_q <= 1'b1;
		end else if (daf_s_q[1]) begin
			cand_vld_q <= 1'b0;
		end
	end
	// Offset updated only while reset is held; last value at release stays
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I)
			ofs_q <= `SDF_OFS_DEF;
		else if (dev_rst)
			ofs_q <= (daf_s_q[1] || !cand_vld_q) ? `SDF_OFS_DEF : cand_q;
	end

	// Storage: flip-flops indexed by pointer
	sdf_pkg::sdf_word_t mem_q [`SDF_DEPTH];
	sdf_pkg::sdf_ptr_t  wptr_q;
	sdf_pkg::sdf_ptr_t  rptr_q;
	sdf_pkg::sdf_ptr_t  wgray_q;
	sdf_pkg::sdf_ptr_t  rgray_q;
	sdf_pkg::sdf_ptr_t  wgray_rs;
	sdf_pkg::sdf_ptr_t  rgray_ws;
	sdf_pkg::sdf_ptr_t  wptr_rs;
	sdf_pkg::sdf_ptr_t  rptr_ws;
	logic               full;
	logic               empty;

	function automatic sdf_pkg::sdf_ptr_t b2g(input sdf_pkg::sdf_ptr_t b);
		return b ^ (b >> 1);
	endfunction

	function automatic sdf_pkg::sdf_ptr_t g2b(input sdf_pkg::sdf_ptr_t g);
		sdf_pkg::sdf_ptr_t b;
		b[`SDF_PW-1] = g[`SDF_PW-1];
		for (int i = `SDF_PW-2; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	// Each pointer is a domain of its own view; Gray copies cross through
	// synchronisers so the opposite side sees a stale but safe count
	sdf_sync #(.W(`SDF_PW)) u_w2r (
		.clk_i (CORE_CLK_I),
		.rst_i (dev_rst),
		.d_i   (wgray_q),
		.q_o   (wgray_rs)
	);
	sdf_sync #(.W(`SDF_PW)) u_r2w (
		.clk_i (CORE_CLK_I),
		.rst_i (dev_rst),
		.d_i   (rgray_q),
		.q_o   (rgray_ws)
	);
	assign wptr_rs = g2b(wgray_rs);
	assign rptr_ws = g2b(rgray_ws);

	assign full  = (wptr_q[`SDF_AW-1:0] == rptr_ws[`SDF_AW-1:0]) &&
	               (wptr_q[`SDF_AW] != rptr_ws[`SDF_AW]);
	wire wr_ok = wr_rise & ~full;

	always_ff @(posedge CORE_CLK_I) begin
		if (dev_rst) begin
			wptr_q  <= `SDF_PTR_ZERO;
			wgray_q <= `SDF_PTR_ZERO;
		end else if (wr_ok) begin
			wptr_q  <= wptr_q + 1'b1;
			wgray_q <= b2g(wptr_q + 1'b1);
		end
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (wr_ok)
			mem_q[wptr_q[`SDF_AW-1:0]] <= din3_q;
	end

	// Read side: a head word is shown once present; read strobe retires it
	sdf_pkg::sdf_rd_st_t st_q;
	sdf_pkg::sdf_ptr_t   next_rd;
	assign empty   = (wptr_rs == rptr_q);
	assign next_rd = rptr_q + 1'b1;
	always_ff @(posedge CORE_CLK_I) begin
		if (dev_rst) begin
			rptr_q  <= `SDF_PTR_ZERO;
			rgray_q <= `SDF_PTR_ZERO;
			st_q    <= sdf_pkg::SDF_IDLE;
		end else begin
			case (st_q)
				sdf_pkg::SDF_IDLE: begin
					if (!empty)
						st_q <= sdf_pkg::SDF_SHOWN;
				end
				sdf_pkg::SDF_SHOWN: begin
					if (rd_rise) begin
						rptr_q  <= next_rd;
						rgray_q <= b2g(next_rd);
						if (wptr_rs == next_rd)
							st_q <= sdf_pkg::SDF_IDLE;
					end
				end
				default: st_q <= sdf_pkg::SDF_IDLE;
			endcase
		end
	end

	// Output word: loaded on fall-through and after each retire that leaves a word; not reset
	always_ff @(posedge CORE_CLK_I) begin
		if (!dev_rst && st_q == sdf_pkg::SDF_IDLE && !empty)
			READ_DATA_OUT_O <= mem_q[rptr_q[`SDF_AW-1:0]];
		else if (!dev_rst && st_q == sdf_pkg::SDF_SHOWN && rd_rise &&
		         wptr_rs != next_rd)
			READ_DATA_OUT_O <= mem_q[next_rd[`SDF_AW-1:0]];
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I)
			READ_DATA_OE_N_O <= '1;
		else
			READ_DATA_OE_N_O <= {`SDF_WIDTH{~oe_s_q[1]}};
	end

	// Flags: full and half use the write side count, empty and the low almost bound the read side count
	sdf_pkg::sdf_ptr_t cnt_w, cnt_r;
	assign cnt_w = wptr_q - rptr_ws;
	assign cnt_r = wptr_rs - rptr_q;
	always_ff @(posedge CORE_CLK_I) begin
		if (dev_rst) begin
			FULL_N_O            <= 1'b1;
			EMPTY_N_O           <= 1'b0;
			HALF_FULL_FLAG_O    <= 1'b0;
			ALMOST_BOUND_FLAG_O <= 1'b1;
		end else begin
			FULL_N_O         <= ~full;
			EMPTY_N_O        <= (st_q == sdf_pkg::SDF_SHOWN) | ~empty;
			HALF_FULL_FLAG_O <= (cnt_w >= `SDF_HALF);
			ALMOST_BOUND_FLAG_O <= (cnt_r <= {2'h0, ofs_q}) ||
			    (cnt_w >= (11'(`SDF_DEPTH) - {2'h0, ofs_q}));
		end
	end
endmodule // sdf_fifo
`default_nettype wire

// file: rtl/sdf_defs.svh
// Constants for the strobed 1k x 18 FIFO
`ifndef SDF_DEFS_SVH
`define SDF_DEFS_SVH
`define SDF_WIDTH      18
`define SDF_DEPTH      1024
`define SDF_AW         10
`define SDF_PW         11
`define SDF_HALF       11'h200
`define SDF_OFS_W      9
`define SDF_OFS_DEF    9'h100
`define SDF_PTR_ZERO   11'h000
`endif

// file: rtl/sdf_pkg.sv
// Types for the strobed 1k x 18 FIFO
`include "sdf_defs.svh"
package sdf_pkg;
	typedef logic [`SDF_PW-1:0] sdf_ptr_t;
	typedef logic [`SDF_WIDTH-1:0] sdf_word_t;
	typedef enum logic [1:0] {SDF_IDLE, SDF_SHOWN} sdf_rd_st_t;
endpackage

// file: rtl/sdf_sync.sv
// Two-flop synchroniser, one per bit, built with a generate loop
`timescale 1ns/10ps
`default_nettype none
module sdf_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,   // Destination clock
	input  wire logic         rst_i,   // Synchronous reset, high
	input  wire logic [W-1:0] d_i,     // Asynchronous input
	output logic      [W-1:0] q_o      // Synchronised output
);
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1_q;
			logic s2_q;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
				end else begin
					s1_q <= d_i[g];
					s2_q <= s1_q;
				end
			end
			assign q_o[g] = s2_q;
		end
	endgenerate
endmodule // sdf_sync
`default_nettype wire

// file: verif/sdf_fifo_properties.sv
// Checker for the strobed FIFO flags, fall-through and output drive
`timescale 1ns/10ps
`default_nettype none
module sdf_fifo_chk (
	input wire logic        CORE_CLK_I,         // Clock
	input wire logic        SYS_RST_I,          // Reset
	input wire logic        RESET_N_I,          // Device reset
	input wire logic        WRITE_STROBE_I,     // Write strobe
	input wire logic        READ_STROBE_I,      // Read strobe
	input wire logic        OUT_ENABLE_I,       // Output enable
	input wire logic [17:0] READ_DATA_OUT_O,    // Read data
	input wire logic [17:0] READ_DATA_OE_N_O,   // Drive enable
	input wire logic        FULL_N_O,           // Full, low
	input wire logic        EMPTY_N_O,          // Empty, low
	input wire logic        HALF_FULL_FLAG_O,   // Half full
	input wire logic        ALMOST_BOUND_FLAG_O // Near a bound
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	rst_flags_a: assert property (!RESET_N_I [*4] |-> FULL_N_O && !EMPTY_N_O
		&& ALMOST_BOUND_FLAG_O && !HALF_FULL_FLAG_O) else $error("reset flags");
	oe_drive_a: assert property ((OUT_ENABLE_I && !SYS_RST_I) [*4]
		|-> READ_DATA_OE_N_O == 18'h00000) else $error("output not driven");
	oe_float_a: assert property ((!OUT_ENABLE_I && !SYS_RST_I) [*4]
		|-> READ_DATA_OE_N_O == 18'h3FFFF) else $error("output not floated");
	full_flags_a: assert property (!FULL_N_O |-> HALF_FULL_FLAG_O && ALMOST_BOUND_FLAG_O
		&& EMPTY_N_O) else $error("flags while full");
	empty_flags_a: assert property (!EMPTY_N_O |-> ALMOST_BOUND_FLAG_O && !HALF_FULL_FLAG_O)
		else $error("flags while empty");
	fall_thru_a: assert property ($changed(READ_DATA_OUT_O) && RESET_N_I
		|-> EMPTY_N_O) else $error("word shown but still empty");
	write_seen_a: assert property (RESET_N_I [*6] ##1 $rose(WRITE_STROBE_I)
		|-> ##[1:8] EMPTY_N_O) else $error("write not seen");
	read_hold_a: assert property ((EMPTY_N_O && !READ_STROBE_I) [*4]
		|=> $stable(READ_DATA_OUT_O)) else $error("data moved without read");
	cover property (!FULL_N_O);
	cover property ($rose(HALF_FULL_FLAG_O));
	cover property ($fell(ALMOST_BOUND_FLAG_O));
	cover property ($rose(EMPTY_N_O));
endmodule // sdf_fifo_chk
bind sdf_fifo sdf_fifo_chk u_chk (.CORE_CLK_I, .SYS_RST_I, .RESET_N_I, .WRITE_STROBE_I,
	.READ_STROBE_I, .OUT_ENABLE_I, .READ_DATA_OUT_O, .READ_DATA_OE_N_O, .FULL_N_O,
	.EMPTY_N_O, .HALF_FULL_FLAG_O, .ALMOST_BOUND_FLAG_O);
`default_nettype wire

// file: verif/sdf_agent.sv
// Writing and reading agents on the FIFO strobe pins
`timescale 1ns/10ps
`default_nettype none
module sdf_agent (
	input  wire logic       clk_i,          // Clock
	output var logic        wr_o = 1'b0,    // Write strobe
	output var logic        rd_o = 1'b0,    // Read strobe
	output var logic [17:0] data_o = 18'h0  // Write data
);
	// Three cycles each way so the pin synchroniser never misses an edge
	task automatic put(input logic [17:0] d, input logic rd);
		data_o <= d;
		repeat (3) @(posedge clk_i);
		wr_o <= !rd;
		rd_o <= rd;
		repeat (3) @(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		data_o <= ~d;
		repeat (3) @(posedge clk_i);
	endtask
endmodule // sdf_agent
`default_nettype wire

// file: verif/strobed_dual_clock_fifo_1k_x18_tb.sv
// Self-checking bench for the strobed FIFO
`timescale 1ns/10ps
`default_nettype none
module strobed_dual_clock_fifo_1k_x18_tb;
	logic        clk = 1'b0, rst = 1'b1, rst_n = 1'b0, ofs_n = 1'b1, oe = 1'b1;
	logic        wr, rd, full_n, empty_n, half, almost;
	logic [17:0] din, dout, oe_n;
	int          mismatches = 0, cmp_count = 0;
	initial forever #5 clk = ~clk;
	sdf_agent u_agt (.clk_i(clk), .wr_o(wr), .rd_o(rd), .data_o(din));
	sdf_fifo u_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .RESET_N_I(rst_n), .WRITE_STROBE_I(wr),
		.READ_STROBE_I(rd), .OFFSET_DEFINE_N_I(ofs_n), .OUT_ENABLE_I(oe), .WRITE_DATA_IN_I(din),
		.READ_DATA_OUT_O(dout), .READ_DATA_OE_N_O(oe_n), .FULL_N_O(full_n),
		.EMPTY_N_O(empty_n), .HALF_FULL_FLAG_O(half), .ALMOST_BOUND_FLAG_O(almost));
	task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Offset value rides on the write data lines while offset-define falls
	task automatic dev_reset(input logic cust, input logic [17:0] x);
		u_agt.data_o <= x;
		@(posedge clk);
		ofs_n <= !cust;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("reset flags", {full_n, empty_n, half, almost}, 18'h00009);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		ofs_n <= 1'b1;
	endtask
	task automatic sc_flow();
		int i;
		u_agt.put(18'h2A5A5, 1'b0);
		for (i = 0; i < 20 && empty_n !== 1'b1; i++) @(posedge clk);
		if (i == 20) begin
			mismatches++;
			end_of_test();
		end
		chk("fall through", dout, 18'h2A5A5);
		u_agt.put(18'h15A5A, 1'b0);
		repeat (4) @(posedge clk);
		chk("held word", dout, 18'h2A5A5);
		u_agt.put(din, 1'b1);
		chk("next word", dout, 18'h15A5A);
		repeat (2) u_agt.put(din, 1'b1);
		repeat (4) @(posedge clk);
		chk("empty", empty_n, 1'b0);
		chk("empty read", dout, 18'h15A5A);
		oe <= 1'b0;
		repeat (4) @(posedge clk);
		chk("floated", oe_n, 18'h3FFFF);
		oe <= 1'b1;
		repeat (4) @(posedge clk);
		chk("driven", oe_n, 18'h00000);
	endtask
	task automatic sc_fill();
		int n;
		for (n = 1; n <= 1025; n++) begin
			u_agt.put(n[17:0], 1'b0);
			repeat (6) @(posedge clk);
			if (n == 256 || n == 257 || n == 767 || n == 768)
				chk("almost", almost, n == 256 || n == 768);
			if (n == 511 || n == 512)
				chk("half", half, n == 512);
		end
		chk("full", full_n, 1'b0);
		u_agt.put(din, 1'b1);
		repeat (6) @(posedge clk);
		chk("second word", dout, 18'h00002);
		chk("not full", full_n, 1'b1);
	endtask
	task automatic sc_ofs();
		dev_reset(1'b1, 18'h00005);
		repeat (5) u_agt.put(18'h00033, 1'b0);
		repeat (6) @(posedge clk);
		chk("at offset", almost, 1'b1);
		u_agt.put(18'h00034, 1'b0);
		repeat (6) @(posedge clk);
		chk("past offset", almost, 1'b0);
		dev_reset(1'b0, 18'h00005);
		repeat (6) u_agt.put(18'h00035, 1'b0);
		repeat (6) @(posedge clk);
		chk("default again", almost, 1'b1);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		dev_reset(1'b0, 18'h00000);
		sc_flow();
		sc_fill();
		sc_ofs();
		end_of_test();
	end
endmodule // strobed_dual_clock_fifo_1k_x18_tb
`default_nettype wire
